// ### src/pcl_defs.svh
// Purpose: Offsets, field positions, reset values and counts of the compare/latch unit
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, one aligned word per register
// Notes:   Definitions only
`ifndef PCL_DEFS_SVH
`define PCL_DEFS_SVH

// Address split: axis block, register index, byte in word
`define PCL_ADDR_W      9
`define PCL_AXIS_MSB    8
`define PCL_AXIS_LSB    6
`define PCL_IDX_MSB     5
`define PCL_IDX_LSB     2

// Register indices inside one axis block
`define PCL_REG_TRIG_CFG  4'h0
`define PCL_REG_TRIG_VAL  4'h1
`define PCL_REG_ERR_CFG   4'h2
`define PCL_REG_ERR_VAL   4'h3
`define PCL_REG_GEN_CFG   4'h4
`define PCL_REG_GEN_VAL   4'h5
`define PCL_REG_CAP_CFG   4'h6
`define PCL_REG_CAP_DATA  4'h7
`define PCL_REG_EVT_STAT  4'h8
`define PCL_REG_EVT_MASK  4'h9

// Field positions in the configuration words
`define PCL_F_SRC_LSB   0
`define PCL_F_SRC_MSB   1
`define PCL_F_METH_LSB  4
`define PCL_F_METH_MSB  6
`define PCL_F_POL       8
`define PCL_F_REACT_LSB 8
`define PCL_F_REACT_MSB 9
`define PCL_F_EDGE      4
`define PCL_F_CSEL_LSB  8
`define PCL_F_CSEL_MSB  9

// Event flag bit positions
`define PCL_EVT_ERR     10
`define PCL_EVT_GEN     11
`define PCL_EVT_TRIG    12
`define PCL_EVT_LTC     14
`define PCL_EVT_ORG     15
`define PCL_EVT_IMPL    16'hDC00

// Reset values and counts
`define PCL_RST_POL     1'b0
`define PCL_RST_EDGE    1'b0
`define PCL_PULSE_CYC   8
`define PCL_NUM_AXES    8
`define PCL_ERR_W       16
`define PCL_ZERO_WORD   32'h0000_0000

`endif

// ### src/pcl_pkg.sv
// Purpose: Types shared by the compare/latch unit files
// Assumes: Codes follow the documented selector encodings
// Notes:   Numbers live in pcl_defs.svh
package pcl_pkg;
  typedef logic [31:0] pcl_word_t;
  typedef logic [15:0] pcl_half_t;
  typedef enum logic [1:0] {PCL_SRC_CMD, PCL_SRC_FB, PCL_SRC_ERR, PCL_SRC_GEN} pcl_src_t;
  typedef enum logic [2:0] {PCL_M_OFF, PCL_M_EQ, PCL_M_EQ_UP, PCL_M_EQ_DN,
                            PCL_M_GT, PCL_M_LT} pcl_meth_t;
  typedef enum logic [1:0] {PCL_R_NONE, PCL_R_STOP, PCL_R_DECEL} pcl_react_t;
  typedef enum logic [1:0] {PCL_CAP_PIN, PCL_CAP_ORG, PCL_CAP_GEN, PCL_CAP_TRIG} pcl_cap_t;
  typedef logic [3:0][31:0] pcl_quad_t;
  typedef struct packed {
    pcl_src_t   trig_src;
    pcl_meth_t  trig_meth;
    logic       trig_pol;
    pcl_word_t  trig_val;
    pcl_meth_t  err_meth;
    pcl_react_t err_react;
    pcl_word_t  err_val;
    pcl_src_t   gen_src;
    pcl_meth_t  gen_meth;
    pcl_react_t gen_react;
    pcl_word_t  gen_val;
    pcl_cap_t   cap_src;
    logic       cap_edge;
    pcl_src_t   cap_csel;
  } pcl_cfg_t;
endpackage

// ### src/pcl_axis.sv
// Purpose: One axis of comparators, compare pulse and counter capture
// Assumes: Counters come from logic on i_clk; pins are asynchronous
// Notes:   Events leave as one-cycle pulses at their status bit positions
`timescale 1ns/10ps
`include "pcl_defs.svh"
module pcl_axis #(
  parameter int PULSE_CYC = `PCL_PULSE_CYC
) (
  input  wire logic               i_clk,
  input  wire logic               i_nrst,
  input  wire pcl_pkg::pcl_word_t i_cmd_cnt,
  input  wire pcl_pkg::pcl_word_t i_fb_cnt,
  input  wire pcl_pkg::pcl_half_t i_err_cnt,
  input  wire pcl_pkg::pcl_word_t i_gen_cnt,
  input  wire logic               i_latch_pin,
  input  wire logic               i_origin_pin,
  input  wire pcl_pkg::pcl_cfg_t  i_cfg,
  output logic                    o_compare_pulse_out,
  output logic                    o_stop_now,
  output logic                    o_decel_stop,
  output pcl_pkg::pcl_half_t      o_evt,
  output pcl_pkg::pcl_quad_t      o_latch
);
  import pcl_pkg::*;

  typedef struct packed {
    logic [2:0]  lsync;
    logic [2:0]  osync;
    logic        llvl;
    logic        olvl;
    logic        primed;
    pcl_quad_t   prev;
    logic [3:0]  up;
    logic        c_err;
    logic        c_gen;
    logic        c_trig;
    logic [7:0]  pcnt;
    logic        pin;
    logic        stop;
    logic        decel;
    pcl_half_t   evt;
    pcl_quad_t   latch;
  } pcl_axis_state_t;

  pcl_axis_state_t s, next_s;
  pcl_quad_t       src4;
  logic [3:0]      up_now;
  logic            e_err, e_gen, e_trig, ltc_ev, org_ev, cap_ev;

  if (PULSE_CYC < 1 || PULSE_CYC > 255) begin : g_chk
    $error("PULSE_CYC must lie in 1..255");
  end

  // Match test for one comparator; codes 6 and 7 never match
  function automatic logic hit(pcl_meth_t m, pcl_word_t v, pcl_word_t c, logic up);
    case (m)
      PCL_M_EQ:    hit = (v == c);
      PCL_M_EQ_UP: hit = (v == c) && up;
      PCL_M_EQ_DN: hit = (v == c) && !up;
      PCL_M_GT:    hit = $signed(v) > $signed(c);
      PCL_M_LT:    hit = $signed(v) < $signed(c);
      default:     hit = 1'b0;
    endcase
  endfunction

  // Counters in selector order, error counter sign-extended
  assign src4 = {i_gen_cnt, {{16{i_err_cnt[`PCL_ERR_W-1]}}, i_err_cnt},
                 i_fb_cnt, i_cmd_cnt};

  // Next state of the whole axis
  always_comb begin
    next_s = s;
    // Pin filters: change counts once stages two and three agree
    next_s.lsync = {s.lsync[1:0], i_latch_pin};
    next_s.osync = {s.osync[1:0], i_origin_pin};
    if (s.lsync[1] == s.lsync[2]) next_s.llvl = s.lsync[2];
    if (s.osync[1] == s.osync[2]) next_s.olvl = s.osync[2];
    next_s.primed = s.primed | ((s.lsync[1] == s.lsync[2]) && (s.osync[1] == s.osync[2]));
    // Count direction follows the last change of each counter
    for (int k = 0; k < 4; k++) begin
      up_now[k] = (src4[k] != s.prev[k]) ? ($signed(src4[k]) > $signed(s.prev[k])) : s.up[k];
    end
    next_s.prev = src4;
    next_s.up   = up_now;
    next_s.c_err  = hit(i_cfg.err_meth, i_cfg.err_val, src4[PCL_SRC_ERR],
                        up_now[PCL_SRC_ERR]);
    next_s.c_gen  = hit(i_cfg.gen_meth, i_cfg.gen_val, src4[i_cfg.gen_src],
                        up_now[i_cfg.gen_src]);
    next_s.c_trig = hit(i_cfg.trig_meth, i_cfg.trig_val, src4[i_cfg.trig_src],
                        up_now[i_cfg.trig_src]);
    // Events fire on entry into the condition only
    e_err  = next_s.c_err & ~s.c_err;
    e_gen  = next_s.c_gen & ~s.c_gen;
    e_trig = next_s.c_trig & ~s.c_trig;
    // Compare pulse stretch and polarity
    if (e_trig) begin
      next_s.pcnt = 8'(PULSE_CYC);
    end else if (s.pcnt != 8'h00) begin
      next_s.pcnt = s.pcnt - 8'h01;
    end
    next_s.pin = (next_s.pcnt != 8'h00) ~^ i_cfg.trig_pol;
    // Motion reactions of error and general comparators
    next_s.stop  = (e_err && i_cfg.err_react == PCL_R_STOP) ||
                   (e_gen && i_cfg.gen_react == PCL_R_STOP);
    next_s.decel = (e_err && i_cfg.err_react == PCL_R_DECEL) ||
                   (e_gen && i_cfg.gen_react == PCL_R_DECEL);
    // Pin edges after the filters have settled
    ltc_ev = s.primed && (next_s.llvl != s.llvl) &&
             (next_s.llvl == i_cfg.cap_edge);
    org_ev = s.primed && next_s.olvl && !s.olvl;
    case (i_cfg.cap_src)
      PCL_CAP_PIN:  cap_ev = ltc_ev;
      PCL_CAP_ORG:  cap_ev = org_ev;
      PCL_CAP_GEN:  cap_ev = e_gen;
      PCL_CAP_TRIG: cap_ev = e_trig;
      default:      cap_ev = 1'b0;
    endcase
    // Capture all four counters, held until the next event
    if (cap_ev) next_s.latch = src4;
    next_s.evt = '0;
    next_s.evt[`PCL_EVT_ERR]  = e_err;
    next_s.evt[`PCL_EVT_GEN]  = e_gen;
    next_s.evt[`PCL_EVT_TRIG] = e_trig;
    next_s.evt[`PCL_EVT_LTC]  = cap_ev && i_cfg.cap_src == PCL_CAP_PIN;
    next_s.evt[`PCL_EVT_ORG]  = cap_ev && i_cfg.cap_src == PCL_CAP_ORG;
  end

  // State register; compare pin idles inactive for reset polarity
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s     <= '0;
      s.pin <= ~`PCL_RST_POL;
    end else begin
      s <= next_s;
    end
  end

  assign o_compare_pulse_out = s.pin;
  assign o_stop_now          = s.stop;
  assign o_decel_stop        = s.decel;
  assign o_evt               = s.evt;
  assign o_latch             = s.latch;
endmodule

// ### src/pcl_top.sv
// Purpose: Multi-axis position compare and latch unit with Avalon-MM registers
// Assumes: Counters arrive on i_clk; latch and origin pins are asynchronous
// Notes:   One wait state per access; status flags are write-one-to-clear
// Operation
// - Every axis owns an independent compare and latch unit, indexed 0..7.
// - Error comparator checks error counter by method, flags host interrupt on match.
// - General comparator has source, method, value, reaction; reacts when met.
// - Trigger match emits a compare output pulse and sets event bit 12.
// - Compare pin polarity per axis: 0 active low, 1 active high.
// - Source codes: 0 command, 1 feedback, 2 error, 3 general counter.
// - Method 4 holds while value exceeds source; 5 while value below source.
// - Reaction 0 none, 1 immediate stop, 2 decelerate then stop.
// - Capture source: 0 latch pin, 1 origin pin, 2 general, 3 trigger match.
// - Latch pin edge selectable: 0 falling (negative), 1 rising (positive).
// - Selected capture event stores the counter values for later reading.
// - Error match sets event bit 10; general match sets bit 11.
// - Latch pin capture sets bit 14; origin pin capture sets bit 15.
// - Error counter is signed, range -32768 to 32767.
//
// Design decisions made here: register access over Avalon-MM and the register addresses.
`timescale 1ns/10ps
`include "pcl_defs.svh"
module pcl_top #(
  parameter int N_AXES    = `PCL_NUM_AXES,
  parameter int PULSE_CYC = `PCL_PULSE_CYC
) (
  input  wire logic                              i_clk,
  input  wire logic                              i_nrst,
  input  wire logic [`PCL_ADDR_W-1:0]            i_address,
  input  wire logic                              i_read,
  input  wire logic                              i_write,
  input  wire pcl_pkg::pcl_word_t                i_writedata,
  input  wire logic [3:0]                        i_byteenable,
  output pcl_pkg::pcl_word_t                     o_readdata,
  output logic                                   o_waitrequest,
  input  wire pcl_pkg::pcl_word_t [N_AXES-1:0]   i_cmd_cnt,
  input  wire pcl_pkg::pcl_word_t [N_AXES-1:0]   i_fb_cnt,
  input  wire pcl_pkg::pcl_half_t [N_AXES-1:0]   i_err_cnt,
  input  wire pcl_pkg::pcl_word_t [N_AXES-1:0]   i_gen_cnt,
  input  wire logic [N_AXES-1:0]                 i_latch_pin,
  input  wire logic [N_AXES-1:0]                 i_origin_pin,
  output logic [N_AXES-1:0]                      o_compare_pulse_out,
  output logic [N_AXES-1:0]                      o_stop_now,
  output logic [N_AXES-1:0]                      o_decel_stop,
  output logic                                   o_irq
);
  import pcl_pkg::*;

  typedef struct packed {
    logic                         waitreq;
    pcl_word_t                    rdata;
    logic                         irq;
    pcl_cfg_t  [N_AXES-1:0]       cfg;
    pcl_half_t [N_AXES-1:0]       stat;
    pcl_half_t [N_AXES-1:0]       mask;
  } pcl_top_state_t;

  localparam pcl_top_state_t RST_STATE = '{waitreq: 1'b1, default: '0};

  pcl_top_state_t          s, next_s;
  pcl_half_t [N_AXES-1:0]  evt;
  pcl_quad_t [N_AXES-1:0]  latch;
  logic [2:0]              axis_idx;
  logic [3:0]              reg_idx;
  logic                    hit_axis;
  logic                    wr_go;
  pcl_word_t               cur_word;
  pcl_word_t               byte_mask;
  pcl_word_t               merged;
  pcl_half_t               clr;
  logic                    irq_any;

  if (N_AXES < 1 || N_AXES > `PCL_NUM_AXES) begin : g_chk_axes
    $error("N_AXES must lie in 1..8");
  end

  // Per-axis comparator and capture units
  for (genvar a = 0; a < N_AXES; a++) begin : g_axis
    pcl_axis #(
      .PULSE_CYC (PULSE_CYC)
    ) u_axis (
      .i_clk               (i_clk),
      .i_nrst              (i_nrst),
      .i_cmd_cnt           (i_cmd_cnt[a]),
      .i_fb_cnt            (i_fb_cnt[a]),
      .i_err_cnt           (i_err_cnt[a]),
      .i_gen_cnt           (i_gen_cnt[a]),
      .i_latch_pin         (i_latch_pin[a]),
      .i_origin_pin        (i_origin_pin[a]),
      .i_cfg               (s.cfg[a]),
      .o_compare_pulse_out (o_compare_pulse_out[a]),
      .o_stop_now          (o_stop_now[a]),
      .o_decel_stop        (o_decel_stop[a]),
      .o_evt               (evt[a]),
      .o_latch             (latch[a])
    );
  end

  // Readable image of one register
  function automatic pcl_word_t word_of(pcl_cfg_t c, logic [3:0] idx, pcl_quad_t q,
                                        pcl_half_t st, pcl_half_t mk);
    pcl_word_t w;
    w = `PCL_ZERO_WORD;
    case (idx)
      `PCL_REG_TRIG_CFG: begin
        w[`PCL_F_SRC_MSB:`PCL_F_SRC_LSB]   = c.trig_src;
        w[`PCL_F_METH_MSB:`PCL_F_METH_LSB] = c.trig_meth;
        w[`PCL_F_POL]                      = c.trig_pol;
      end
      `PCL_REG_TRIG_VAL: w = c.trig_val;
      `PCL_REG_ERR_CFG: begin
        w[`PCL_F_METH_MSB:`PCL_F_METH_LSB]   = c.err_meth;
        w[`PCL_F_REACT_MSB:`PCL_F_REACT_LSB] = c.err_react;
      end
      `PCL_REG_ERR_VAL: w = c.err_val;
      `PCL_REG_GEN_CFG: begin
        w[`PCL_F_SRC_MSB:`PCL_F_SRC_LSB]     = c.gen_src;
        w[`PCL_F_METH_MSB:`PCL_F_METH_LSB]   = c.gen_meth;
        w[`PCL_F_REACT_MSB:`PCL_F_REACT_LSB] = c.gen_react;
      end
      `PCL_REG_GEN_VAL: w = c.gen_val;
      `PCL_REG_CAP_CFG: begin
        w[`PCL_F_SRC_MSB:`PCL_F_SRC_LSB]   = c.cap_src;
        w[`PCL_F_EDGE]                     = c.cap_edge;
        w[`PCL_F_CSEL_MSB:`PCL_F_CSEL_LSB] = c.cap_csel;
      end
      `PCL_REG_CAP_DATA: w = q[c.cap_csel];
      `PCL_REG_EVT_STAT: w[15:0] = st & `PCL_EVT_IMPL;
      `PCL_REG_EVT_MASK: w[15:0] = mk & `PCL_EVT_IMPL;
      default:           w = `PCL_ZERO_WORD;
    endcase
    return w;
  endfunction

  // Apply a merged write word to the configuration fields
  function automatic pcl_cfg_t cfg_write(pcl_cfg_t c, logic [3:0] idx, pcl_word_t w);
    pcl_cfg_t n;
    n = c;
    case (idx)
      `PCL_REG_TRIG_CFG: begin
        n.trig_src  = pcl_src_t'(w[`PCL_F_SRC_MSB:`PCL_F_SRC_LSB]);
        n.trig_meth = pcl_meth_t'(w[`PCL_F_METH_MSB:`PCL_F_METH_LSB]);
        n.trig_pol  = w[`PCL_F_POL];
      end
      `PCL_REG_TRIG_VAL: n.trig_val = w;
      `PCL_REG_ERR_CFG: begin
        n.err_meth  = pcl_meth_t'(w[`PCL_F_METH_MSB:`PCL_F_METH_LSB]);
        n.err_react = pcl_react_t'(w[`PCL_F_REACT_MSB:`PCL_F_REACT_LSB]);
      end
      `PCL_REG_ERR_VAL: n.err_val = w;
      `PCL_REG_GEN_CFG: begin
        n.gen_src   = pcl_src_t'(w[`PCL_F_SRC_MSB:`PCL_F_SRC_LSB]);
        n.gen_meth  = pcl_meth_t'(w[`PCL_F_METH_MSB:`PCL_F_METH_LSB]);
        n.gen_react = pcl_react_t'(w[`PCL_F_REACT_MSB:`PCL_F_REACT_LSB]);
      end
      `PCL_REG_GEN_VAL: n.gen_val = w;
      `PCL_REG_CAP_CFG: begin
        n.cap_src  = pcl_cap_t'(w[`PCL_F_SRC_MSB:`PCL_F_SRC_LSB]);
        n.cap_edge = w[`PCL_F_EDGE];
        n.cap_csel = pcl_src_t'(w[`PCL_F_CSEL_MSB:`PCL_F_CSEL_LSB]);
      end
      default: n = c;
    endcase
    return n;
  endfunction

  // Address decode of the current request
  assign axis_idx = i_address[`PCL_AXIS_MSB:`PCL_AXIS_LSB];
  assign reg_idx  = i_address[`PCL_IDX_MSB:`PCL_IDX_LSB];
  assign hit_axis = ({29'h0000_0000, axis_idx} < N_AXES);

  // Bus slave, register file, sticky status and interrupt
  always_comb begin
    next_s    = s;
    cur_word  = `PCL_ZERO_WORD;
    merged    = `PCL_ZERO_WORD;
    clr       = '0;
    irq_any   = 1'b0;
    byte_mask = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
                 {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
    if (hit_axis) begin
      cur_word = word_of(s.cfg[axis_idx], reg_idx, latch[axis_idx],
                         s.stat[axis_idx], s.mask[axis_idx]);
    end
    merged = (cur_word & ~byte_mask) | (i_writedata & byte_mask);
    // Write takes effect at the edge where waitrequest is low
    wr_go = i_write && !s.waitreq && hit_axis;
    // First cycle of a request: capture read data, drop waitrequest
    if ((i_read || i_write) && s.waitreq) begin
      next_s.waitreq = 1'b0;
      next_s.rdata   = (i_read && hit_axis) ? cur_word : `PCL_ZERO_WORD;
    end else begin
      next_s.waitreq = 1'b1;
    end
    if (wr_go) begin
      next_s.cfg[axis_idx] = cfg_write(s.cfg[axis_idx], reg_idx, merged);
      if (reg_idx == `PCL_REG_EVT_MASK) next_s.mask[axis_idx] = merged[15:0];
    end
    for (int a = 0; a < N_AXES; a++) begin
      clr = (wr_go && axis_idx == 3'(a) && reg_idx == `PCL_REG_EVT_STAT) ?
            (i_writedata[15:0] & byte_mask[15:0]) : 16'h0000;
      // Set wins over a clear in the same cycle
      next_s.stat[a] = ((s.stat[a] & ~clr) | evt[a]) & `PCL_EVT_IMPL;
      irq_any = irq_any | (|(next_s.stat[a] & next_s.mask[a]));
    end
    next_s.irq = irq_any;
  end

  // State register
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s <= RST_STATE;
    end else begin
      s <= next_s;
    end
  end

  assign o_readdata    = s.rdata;
  assign o_waitrequest = s.waitreq;
  assign o_irq         = s.irq;
endmodule

// ### test/pcl_monitor.sv
// Purpose: Port-level timing checks on pcl_top
// Assumes: Axis 0 outputs are watched
// Notes:   Bus checks assume one wait state
`timescale 1ns/10ps
`include "pcl_defs.svh"
module pcl_monitor #(
  parameter int N_AXES    = 2,
  parameter int PULSE_CYC = 3
) (
  input wire logic                    i_clk,
  input wire logic                    i_nrst,
  input wire logic [`PCL_ADDR_W-1:0]  i_address,
  input wire logic                    i_read,
  input wire logic                    i_write,
  input wire pcl_pkg::pcl_word_t      o_readdata,
  input wire logic                    o_waitrequest,
  input wire logic [N_AXES-1:0]       o_compare_pulse_out,
  input wire logic [N_AXES-1:0]       o_stop_now,
  input wire logic [N_AXES-1:0]       o_decel_stop
);
  default clocking mcb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  // Bus hand-over
  AST_ONE_WAIT: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("no answer");
  AST_ACK_ONE_CYCLE: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("ack too long");
  AST_NO_IDLE_ACK: assert property (!(i_read || i_write) |=> o_waitrequest)
    else $error("idle ack");
  AST_UNMAPPED_ZERO: assert property (i_read && !o_waitrequest &&
    (i_address[8:6] >= N_AXES || i_address[5:2] >= 4'hA) |-> o_readdata == 32'h0000_0000)
    else $error("unmapped read");
  AST_STAT_RESERVED: assert property (i_read && !o_waitrequest && i_address[5:2] == 4'h8
    |-> (o_readdata & ~32'h0000_DC00) == 32'h0000_0000)
    else $error("reserved bit");
  AST_READ_HOLD: assert property (!o_waitrequest ##1 !(i_read || i_write) |-> $stable(o_readdata))
    else $error("readdata moved");
  // Output pulse widths
  AST_PULSE_HOLD: assert property ($changed(o_compare_pulse_out[0])
    |=> $stable(o_compare_pulse_out[0])[*2])
    else $error("pin level short");
  AST_STOP_PULSE: assert property (o_stop_now[0] |=> !o_stop_now[0])
    else $error("long stop");
  AST_DECEL_PULSE: assert property ($rose(o_decel_stop[0]) |=> $fell(o_decel_stop[0]))
    else $error("long decel");
  AST_NO_DOUBLE_REACT: assert property (o_stop_now[0] |-> !o_decel_stop[0])
    else $error("stop with decel");
  // Scenarios
  COV_READ: cover property (i_read && !o_waitrequest);
  COV_PULSE: cover property ($rose(o_compare_pulse_out[0]));
  COV_STOP: cover property (o_stop_now[0]);
  COV_DECEL: cover property (o_decel_stop[0]);
endmodule

// ### test/pcl_sensor_model.sv
// Purpose: Latch/origin sensors and compare pulse receiver
// Assumes: Sensor pulses last 10 cycles, idle low
// Notes:   Counts rising edges of the compare pin
`timescale 1ns/10ps
module pcl_sensor_model (
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_go_latch,
  input  wire logic i_go_origin,
  input  wire logic i_cmp_pin,
  output logic      o_latch_pin,
  output logic      o_origin_pin,
  output int        o_cmp_cnt
);
  int   lat_left;
  int   org_left;
  logic cmp_prev;
  // Sensor timers and receiver
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lat_left  <= 0;
      org_left  <= 0;
      cmp_prev  <= 1'b1;
      o_cmp_cnt <= 0;
    end else begin
      lat_left <= i_go_latch ? 10 : (lat_left > 0 ? lat_left - 1 : 0);
      org_left <= i_go_origin ? 10 : (org_left > 0 ? org_left - 1 : 0);
      cmp_prev <= i_cmp_pin;
      if (i_cmp_pin && !cmp_prev)
        o_cmp_cnt <= o_cmp_cnt + 1;
    end
  end
  assign o_latch_pin  = (lat_left > 0);
  assign o_origin_pin = (org_left > 0);
endmodule

// ### test/position_compare_latch_bench.sv
// Purpose: Self-checking bench for the compare/latch unit
// Assumes: Two axes, 3-cycle pulse; axis 1 counters at zero
// Notes:   Table rows for source and method codes
`timescale 1ns/10ps
`include "pcl_defs.svh"
module position_compare_latch_bench;
  import pcl_pkg::*;
  typedef struct {int src; int meth; pcl_word_t val, c0, c1; logic ev;} pcl_row_t;
  logic                  i_clk = 1'b0;
  logic                  i_nrst = 1'b0;
  logic [8:0]            i_address = 9'h000;
  logic                  i_read = 1'b0;
  logic                  i_write = 1'b0;
  pcl_word_t             i_writedata = 32'h0;
  pcl_word_t             o_readdata;
  logic                  o_waitrequest;
  pcl_word_t [1:0]       i_cmd_cnt = '0;
  pcl_word_t [1:0]       i_fb_cnt = '0;
  pcl_half_t [1:0]       i_err_cnt = '0;
  pcl_word_t [1:0]       i_gen_cnt = '0;
  logic [1:0]            o_compare_pulse_out;
  logic [1:0]            o_stop_now;
  logic [1:0]            o_decel_stop;
  logic                  o_irq;
  logic                  go_lat = 1'b0;
  logic                  go_org = 1'b0;
  logic                  lat_pin;
  logic                  org_pin;
  int                    cmp_cnt;
  int                    n_fail = 0;
  int                    check_count = 0;
  int                    n_stop = 0;
  int                    n_dec = 0;
  int                    s0;
  int                    n_ev = 0;
  pcl_word_t             d;
  pcl_row_t rows [10] = '{'{0, 1, 5, 4, 5, 1}, '{1, 2, 5, 4, 5, 1}, '{2, 3, 5, 6, 5, 1},
    '{3, 2, 5, 6, 5, 0}, '{0, 3, 5, 4, 5, 0}, '{1, 0, 5, 4, 5, 0}, '{2, 4, 5, 6, 3, 1},
    '{3, 5, 5, 3, 7, 1}, '{0, 4, 5, 3, 7, 0}, '{2, 1, -2, 0, -2, 1}};
  pcl_top #(.N_AXES(2), .PULSE_CYC(3)) u_dut (.i_clk, .i_nrst, .i_address, .i_read, .i_write,
    .i_writedata, .i_byteenable(4'hF), .o_readdata, .o_waitrequest, .i_cmd_cnt, .i_fb_cnt,
    .i_err_cnt, .i_gen_cnt, .i_latch_pin({2{lat_pin}}), .i_origin_pin({2{org_pin}}),
    .o_compare_pulse_out, .o_stop_now, .o_decel_stop, .o_irq);
  pcl_sensor_model u_sens (.i_clk, .i_nrst, .i_go_latch(go_lat), .i_go_origin(go_org),
    .i_cmp_pin(o_compare_pulse_out[0]), .o_latch_pin(lat_pin), .o_origin_pin(org_pin),
    .o_cmp_cnt(cmp_cnt));
  // Clock and reaction counters
  always #2 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    n_stop += (o_stop_now[0] === 1'b1);
    n_dec  += (o_decel_stop[0] === 1'b1);
  end
  task automatic give_verdict();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input pcl_word_t e, input pcl_word_t g);
    check_count++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  // One access, held until waitrequest low
  task automatic bus(input logic w, input int ax, input int ix, input pcl_word_t wd,
                     output pcl_word_t rd);
    int n;
    n = 0;
    @(posedge i_clk);
    i_address   <= 9'(ax * 64 + ix * 4);
    i_writedata <= wd;
    i_read      <= !w;
    i_write     <= w;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 20);
    rd = o_readdata;
    i_read  <= 1'b0;
    i_write <= 1'b0;
    if (n >= 20) begin
      n_fail++;
      give_verdict();
    end
  endtask
  task automatic wr(input int ax, input int ix, input pcl_word_t v);
    pcl_word_t x;
    bus(1'b1, ax, ix, v, x);
  endtask
  task automatic rd(input int ax, input int ix, output pcl_word_t v);
    bus(1'b0, ax, ix, 32'h0, v);
  endtask
  task automatic set_cnt(input int s, input pcl_word_t v);
    @(posedge i_clk);
    case (s)
      0: i_cmd_cnt[0] <= v;
      1: i_fb_cnt[0] <= v;
      2: i_err_cnt[0] <= v[15:0];
      default: i_gen_cnt[0] <= v;
    endcase
  endtask
  task automatic set_all(input pcl_word_t b);
    for (int k = 0; k < 4; k++)
      set_cnt(k, b + k + 1);
  endtask
  task automatic pulse(input logic origin_input_pin);
    @(posedge i_clk);
    go_lat <= !origin_input_pin;
    go_org <= origin_input_pin;
    @(posedge i_clk);
    go_lat <= 1'b0;
    go_org <= 1'b0;
  endtask
  // Watchdog
  initial begin
    repeat (60000) @(posedge i_clk);
    n_fail++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge i_clk);
    #1 chk("rst_pins", 32'h3, 32'(o_compare_pulse_out));
    chk("rst_wait", 32'h1, 32'(o_waitrequest));
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    rd(0, 0, d);
    chk("rst_trig_cfg", 32'h0, d);
    rd(0, 9, d);
    chk("rst_mask", 32'h0, d);
    // Trigger source and method rows
    foreach (rows[i]) begin
      set_cnt(rows[i].src, rows[i].c0);
      wr(0, 1, rows[i].val);
      wr(0, 0, rows[i].src | (rows[i].meth << 4) | 32'h100);
      wr(0, 8, 32'h0000_FFFF);
      set_cnt(rows[i].src, rows[i].c1);
      repeat (2) @(posedge i_clk);
      #1 chk("pulse", 32'(rows[i].ev), 32'(o_compare_pulse_out[0]));
      rd(0, 8, d);
      chk("trig_evt", 32'(rows[i].ev), 32'(d[12]));
      n_ev += rows[i].ev;
    end
    chk("pulse_count", n_ev, cmp_cnt);
    wr(0, 0, 32'h100);
    // General reactions, one event per entry
    for (int r = 0; r < 4; r++) begin
      set_cnt(0, 8);
      wr(0, 5, 9);
      wr(0, 4, 32'h10 | (r << 8));
      s0 = n_stop + n_dec * 16;
      set_cnt(0, 9);
      repeat (6) @(posedge i_clk);
      chk("react", (r == 1) + (r == 2) * 16, n_stop + n_dec * 16 - s0);
      rd(0, 8, d);
      chk("gen_evt", 32'h1, 32'(d[11]));
      wr(0, 8, 32'h0000_FFFF);
      rd(0, 8, d);
      chk("gen_once", 32'h0, 32'(d[11]));
    end
    // Error compare, stop
    wr(0, 4, 32'h0);
    set_cnt(2, 2);
    wr(0, 3, 3);
    wr(0, 2, 32'h110);
    s0 = n_stop;
    set_cnt(2, 3);
    repeat (6) @(posedge i_clk);
    chk("err_stop", s0 + 1, n_stop);
    rd(0, 8, d);
    chk("err_evt", 32'h1, 32'(d[10]));
    wr(0, 2, 32'h0);
    // Latch pin capture, rising then falling edge
    for (int e = 1; e >= 0; e--) begin
      set_all(32'h10);
      wr(0, 6, e << 4);
      wr(0, 8, 32'h0000_FFFF);
      pulse(1'b0);
      repeat (5) @(posedge i_clk);
      set_all(32'h20);
      repeat (12) @(posedge i_clk);
      set_all(32'h30);
      for (int c = 0; c < 4; c++) begin
        wr(0, 6, (e << 4) | (c << 8));
        rd(0, 7, d);
        chk("cap_data", (e ? 32'h10 : 32'h20) + c + 1, d);
      end
      rd(0, 8, d);
      chk("cap_pin_evt", 32'h1, 32'(d[14]));
    end
    // Origin pin capture
    wr(0, 6, 32'h1);
    wr(0, 8, 32'h0000_FFFF);
    pulse(1'b1);
    repeat (10) @(posedge i_clk);
    rd(0, 7, d);
    chk("org_data", 32'h31, d);
    rd(0, 8, d);
    chk("org_evt", 32'h8000, d & 32'hC000);
    // Capture on matches
    wr(0, 5, 9);
    wr(0, 4, 32'h10);
    wr(0, 1, 9);
    wr(0, 0, 32'h110);
    for (int s = 2; s < 4; s++) begin
      set_all(32'h50);
      wr(0, 6, s);
      set_all(32'h8);
      repeat (4) @(posedge i_clk);
      set_all(32'h50);
      rd(0, 7, d);
      chk("cap_cmp", 32'h9, d);
    end
    // Interrupt masking and clearing
    wr(0, 9, 32'h0);
    #1 chk("irq_masked", 32'h0, 32'(o_irq));
    wr(0, 9, 32'h0000_FFFF);
    #1 chk("irq_on", 32'h1, 32'(o_irq));
    rd(0, 9, d);
    chk("mask_bits", 32'h0000_DC00, d);
    wr(0, 8, 32'h0000_FFFF);
    #1 chk("irq_clr", 32'h0, 32'(o_irq));
    // Unmapped and axis 1
    rd(2, 0, d);
    chk("no_axis", 32'h0, d);
    rd(0, 10, d);
    chk("no_reg", 32'h0, d);
    rd(1, 8, d);
    chk("axis1_evt", 32'h0, d & 32'h1C00);
    // Second reset in mid-run
    @(posedge i_clk);
    i_nrst <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_nrst <= 1'b1;
    rd(0, 0, d);
    chk("rst2_cfg", 32'h0, d);
    chk("rst2_pins", 32'h3, 32'(o_compare_pulse_out));
    give_verdict();
  end
endmodule
bind pcl_top pcl_monitor #(.N_AXES(N_AXES), .PULSE_CYC(PULSE_CYC)) u_mon (.i_clk, .i_nrst,
  .i_address, .i_read, .i_write, .o_readdata, .o_waitrequest, .o_compare_pulse_out,
  .o_stop_now, .o_decel_stop);
